// ===== src/dspace_map.vh
`ifndef DSPACE_MAP_VH
`define DSPACE_MAP_VH

// address space boundaries
`define ONCHIP_TOP      16'h7fff
`define WINDOW_BASE     16'h8000
`define NEAR_TOP        16'h1fff
`define REGION_TOP      16'h07ff
`define NEAR_FIELD_W    13
`define BLOCK_SHIFT     5
`define BLOCK_COUNT     64
`define BLOCK_IDX_W     6
// pointer steps
`define STEP_BYTE       16'h0001
`define STEP_WORD       16'h0002
// byte lanes
`define LANE_LO         2'b01
`define LANE_HI         2'b10
`define LANE_BOTH       2'b11
`define LANE_NONE       2'b00
// extension operations
`define XOP_NONE        2'h0
`define XOP_SIGN        2'h1
`define XOP_ZERO        2'h2
// address modes
`define AMODE_INDIRECT  2'h0
`define AMODE_NEAR      2'h1
`define AMODE_FULL      2'h2
// implemented register blocks default map
`define BLOCK_MAP_DEF   64'h0000_0000_0000_ffff

`endif

// ===== src/address_generator.v
`timescale 1ns/1ps
`include "dspace_map.vh"

module address_generator (
	input  wire [1:0]  amode,
	input  wire [15:0] pointer_value,
	input  wire [15:0] direct_field,
	input  wire        is_move,
	input  wire        byte_op,
	input  wire        post_inc,
	output reg  [15:0] effective_byte_address,
	output reg  [15:0] pointer_next,
	output reg         mode_fault
);
	// ----------------------------------------
	// effective address and pointer update
	// ----------------------------------------
	always @* begin
		effective_byte_address = pointer_value;
		pointer_next           = pointer_value;
		mode_fault             = 1'b0;
		case (amode)
		`AMODE_INDIRECT: begin
			effective_byte_address = pointer_value;
			if (post_inc) begin
				pointer_next = pointer_value + (byte_op ? `STEP_BYTE : `STEP_WORD); // [R4]
			end
		end
		`AMODE_NEAR: begin
			effective_byte_address = {3'h0, direct_field[`NEAR_FIELD_W-1:0]}; // [R11]
		end
		`AMODE_FULL: begin
			effective_byte_address = direct_field; // [R12]
			mode_fault             = ~is_move; // [R11]
		end
		default: begin
			mode_fault = 1'b1;
		end
		endcase
	end
endmodule

// ===== src/byte_lane_unit.v
`timescale 1ns/1ps
`include "dspace_map.vh"

module byte_lane_unit (
	input  wire [15:0] word_in,
	input  wire        byte_sel,
	input  wire        byte_op,
	input  wire [15:0] reg_old,
	input  wire [1:0]  xop,
	output reg  [15:0] reg_value
);
	reg [7:0] picked;

	// ----------------------------------------
	// byte selection and widening
	// ----------------------------------------
	always @* begin
		picked    = byte_sel ? word_in[15:8] : word_in[7:0]; // [R5]
		reg_value = word_in;
		if (byte_op) begin
			reg_value = {reg_old[15:8], picked}; // [R9]
		end
		case (xop)
		`XOP_SIGN: begin
			reg_value = {{8{reg_value[7]}}, reg_value[7:0]}; // [R10]
		end
		`XOP_ZERO: begin
			reg_value = {8'h00, reg_value[7:0]}; // [R10]
		end
		default: begin
			reg_value = reg_value;
		end
		endcase
	end
endmodule

// ===== src/data_space_access_unit.v
`timescale 1ns/1ps
`include "dspace_map.vh"

// Behaviour
// R1: byte addresses; lower half maps on-chip memory
// R2: upper half goes through extended window
// R3: even address low byte, odd high
// R4: post-increment by one byte, two word
// R5: byte read picks byte onto low lane
// R6: shared word decode, separate byte strobes
// R7: odd word access raises address error
// R8: read completes; write suppressed; then trap
// R9: byte load keeps register high byte
// R10: sign widen and zero widen operations
// R11: near region via 13-bit direct field
// R12: move reaches whole space, 16-bit field
// R13: lowest 2 KB decodes as register region
// R14: unimplemented register addresses read zero
// R15: separate read and write address generators
// R16: register region decoded in 32-byte blocks
// R17: hold address error until acknowledged
module data_space_access_unit #(
	parameter [`BLOCK_COUNT-1:0] BLOCK_MAP = `BLOCK_MAP_DEF
) (
	input  wire        REF_CLK,
	input  wire        RST,
	input  wire        RD_REQ,
	input  wire [1:0]  RD_AMODE,
	input  wire [15:0] RD_POINTER,
	input  wire [15:0] RD_FIELD,
	input  wire        RD_IS_MOVE,
	input  wire        RD_BYTE,
	input  wire        RD_POST_INC,
	input  wire [1:0]  RD_XOP,
	input  wire [15:0] RD_REG_OLD,
	input  wire        WR_REQ,
	input  wire [1:0]  WR_AMODE,
	input  wire [15:0] WR_POINTER,
	input  wire [15:0] WR_FIELD,
	input  wire        WR_IS_MOVE,
	input  wire        WR_BYTE,
	input  wire        WR_POST_INC,
	input  wire [15:0] WR_DATA,
	input  wire [15:0] MEM_RDATA,
	input  wire [15:0] SREG_RDATA,
	input  wire [15:0] WIN_RDATA,
	input  wire        TRAP_ACK,
	output wire [14:0] MEM_WORD_ADDR,
	output wire        MEM_SEL,
	output wire        SREG_SEL,
	output wire        WIN_SEL,
	output reg  [1:0]  MEM_WE,
	output reg  [1:0]  SREG_WE,
	output reg  [1:0]  WIN_WE,
	output reg  [14:0] WR_WORD_ADDR,
	output reg  [15:0] WR_LANE_DATA,
	output reg  [15:0] RD_VALUE,
	output reg         RD_VALID,
	output reg  [15:0] RD_POINTER_NEXT,
	output reg  [15:0] WR_POINTER_NEXT,
	output reg         ADDR_ERR,
	output reg         MODE_ERR
);
	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function is_window;
		input [15:0] a;
		begin
			is_window = (a >= `WINDOW_BASE); // [R2]
		end
	endfunction

	function is_region;
		input [15:0] a;
		begin
			is_region = (a <= `REGION_TOP); // [R13]
		end
	endfunction

	function block_live;
		input [15:0] a;
		reg [`BLOCK_IDX_W-1:0] idx;
		begin
			idx        = a[`BLOCK_SHIFT+`BLOCK_IDX_W-1:`BLOCK_SHIFT];
			block_live = BLOCK_MAP[idx]; // [R16]
		end
	endfunction

	function [1:0] lanes;
		input [15:0] a;
		input        byte_op;
		begin
			if (!byte_op) begin
				lanes = `LANE_BOTH;
			end else if (a[0]) begin
				lanes = `LANE_HI; // [R3]
			end else begin
				lanes = `LANE_LO; // [R3]
			end
		end
	endfunction

	// ----------------------------------------
	// two independent address generators
	// ----------------------------------------
	wire [15:0] rd_ea;
	wire [15:0] wr_ea;
	wire [15:0] rd_ptr_n;
	wire [15:0] wr_ptr_n;
	wire        rd_mfault;
	wire        wr_mfault;

	address_generator u_rd_gen ( // [R15]
		.amode                  (RD_AMODE),
		.pointer_value          (RD_POINTER),
		.direct_field           (RD_FIELD),
		.is_move                (RD_IS_MOVE),
		.byte_op                (RD_BYTE),
		.post_inc               (RD_POST_INC),
		.effective_byte_address (rd_ea),
		.pointer_next           (rd_ptr_n),
		.mode_fault             (rd_mfault)
	);

	address_generator u_wr_gen ( // [R15]
		.amode                  (WR_AMODE),
		.pointer_value          (WR_POINTER),
		.direct_field           (WR_FIELD),
		.is_move                (WR_IS_MOVE),
		.byte_op                (WR_BYTE),
		.post_inc               (WR_POST_INC),
		.effective_byte_address (wr_ea),
		.pointer_next           (wr_ptr_n),
		.mode_fault             (wr_mfault)
	);

	// ----------------------------------------
	// read path: select and decode
	// ----------------------------------------
	wire rd_misalign = RD_REQ & ~RD_BYTE & rd_ea[0]; // [R7]
	wire wr_misalign = WR_REQ & ~WR_BYTE & wr_ea[0]; // [R7]
	wire rd_go       = RD_REQ & ~rd_mfault;
	wire wr_go       = WR_REQ & ~wr_mfault & ~wr_misalign; // [R8]

	// shared word decode for both lanes
	assign MEM_WORD_ADDR = rd_ea[15:1]; // [R6]
	assign WIN_SEL       = rd_go & is_window(rd_ea); // [R2]
	assign SREG_SEL      = rd_go & is_region(rd_ea) & block_live(rd_ea); // [R13]
	assign MEM_SEL       = rd_go & ~is_window(rd_ea) & ~is_region(rd_ea); // [R1]

	reg         rd_pend_reg;
	reg         rd_byte_reg;
	reg         rd_sel_hi_reg;
	reg  [1:0]  rd_src_reg;
	reg  [1:0]  rd_xop_reg;
	reg  [15:0] rd_old_reg;
	reg  [15:0] word_mux;
	wire [15:0] lane_value;

	localparam [1:0] SRC_MEM  = 2'h0;
	localparam [1:0] SRC_SREG = 2'h1;
	localparam [1:0] SRC_WIN  = 2'h2;
	localparam [1:0] SRC_ZERO = 2'h3;

	always @(posedge REF_CLK) begin
		if (RST) begin
			rd_pend_reg   <= 1'b0;
			rd_byte_reg   <= 1'b0;
			rd_sel_hi_reg <= 1'b0;
			rd_src_reg    <= SRC_ZERO;
			rd_xop_reg    <= `XOP_NONE;
			rd_old_reg    <= 16'h0000;
		end else begin
			// a misaligned read still completes
			rd_pend_reg   <= rd_go; // [R8]
			rd_byte_reg   <= RD_BYTE;
			rd_sel_hi_reg <= rd_ea[0]; // [R5]
			rd_xop_reg    <= RD_XOP;
			rd_old_reg    <= RD_REG_OLD;
			if (WIN_SEL) begin
				rd_src_reg <= SRC_WIN;
			end else if (SREG_SEL) begin
				rd_src_reg <= SRC_SREG;
			end else if (MEM_SEL) begin
				rd_src_reg <= SRC_MEM;
			end else begin
				rd_src_reg <= SRC_ZERO; // [R14]
			end
		end
	end

	always @* begin
		case (rd_src_reg)
		SRC_MEM:  word_mux = MEM_RDATA;
		SRC_SREG: word_mux = SREG_RDATA;
		SRC_WIN:  word_mux = WIN_RDATA;
		default:  word_mux = 16'h0000; // [R14]
		endcase
	end

	byte_lane_unit u_lane (
		.word_in   (word_mux),
		.byte_sel  (rd_sel_hi_reg),
		.byte_op   (rd_byte_reg),
		.reg_old   (rd_old_reg),
		.xop       (rd_xop_reg),
		.reg_value (lane_value)
	);

	always @(posedge REF_CLK) begin
		if (RST) begin
			RD_VALUE <= 16'h0000;
			RD_VALID <= 1'b0;
		end else begin
			RD_VALUE <= lane_value; // [R5] [R9] [R10]
			RD_VALID <= rd_pend_reg;
		end
	end

	// ----------------------------------------
	// write path: per-lane strobes
	// ----------------------------------------
	wire [1:0] wr_lanes = wr_go ? lanes(wr_ea, WR_BYTE) : `LANE_NONE; // [R6]

	always @(posedge REF_CLK) begin
		if (RST) begin
			MEM_WE       <= `LANE_NONE;
			SREG_WE      <= `LANE_NONE;
			WIN_WE       <= `LANE_NONE;
			WR_WORD_ADDR <= 15'h0000;
			WR_LANE_DATA <= 16'h0000;
		end else begin
			WR_WORD_ADDR <= wr_ea[15:1]; // [R6]
			if (WR_BYTE) begin
				WR_LANE_DATA <= {WR_DATA[7:0], WR_DATA[7:0]}; // [R3]
			end else begin
				WR_LANE_DATA <= WR_DATA;
			end
			MEM_WE  <= (~is_window(wr_ea) & ~is_region(wr_ea)) ? wr_lanes : `LANE_NONE; // [R1]
			SREG_WE <= (is_region(wr_ea) & block_live(wr_ea)) ? wr_lanes : `LANE_NONE; // [R16]
			WIN_WE  <= is_window(wr_ea) ? wr_lanes : `LANE_NONE; // [R2]
		end
	end

	// ----------------------------------------
	// pointers and trap flags
	// ----------------------------------------
	reg err_seen_reg;

	always @(posedge REF_CLK) begin
		if (RST) begin
			RD_POINTER_NEXT <= 16'h0000;
			WR_POINTER_NEXT <= 16'h0000;
			ADDR_ERR        <= 1'b0;
			err_seen_reg    <= 1'b0;
			MODE_ERR        <= 1'b0;
		end else begin
			RD_POINTER_NEXT <= rd_ptr_n; // [R4]
			WR_POINTER_NEXT <= wr_ptr_n; // [R4]
			MODE_ERR        <= (RD_REQ & rd_mfault) | (WR_REQ & wr_mfault); // [R11]
			if ((rd_misalign | wr_misalign) & ~err_seen_reg) begin
				ADDR_ERR     <= 1'b1; // [R7] [R17]
				err_seen_reg <= 1'b1;
			end else if (TRAP_ACK) begin
				ADDR_ERR <= 1'b0; // [R17]
			end
			if (~(rd_misalign | wr_misalign)) begin
				err_seen_reg <= ADDR_ERR & ~TRAP_ACK;
			end
		end
	end
endmodule

// ===== tb/dspace_far_model.sv
`timescale 1ns/1ps
module dspace_far_model (
	input  wire        clk,
	input  wire        mem_sel,
	input  wire        sreg_sel,
	input  wire        win_sel,
	input  wire [14:0] word_addr,
	output reg  [15:0] mem_rdata,
	output reg  [15:0] sreg_rdata,
	output reg  [15:0] win_rdata
);
	// ---------------------------------------------
	// read data one cycle after select
	// ---------------------------------------------
	// unselected lanes toggle so a stale value never matches by chance
	initial begin
		mem_rdata = 16'h0000;
		sreg_rdata = 16'h0000;
		win_rdata = 16'h0000;
	end
	always @(posedge clk) begin
		mem_rdata <= mem_sel ? ({1'b0, word_addr} ^ 16'h1234) : ~mem_rdata;
		sreg_rdata <= sreg_sel ? ({1'b0, word_addr} ^ 16'h4321) : ~sreg_rdata;
		win_rdata <= win_sel ? ({1'b0, word_addr} ^ 16'h8765) : ~win_rdata;
	end
endmodule

// ===== tb/data_space_access_unit_sva.sv
`timescale 1ns/1ps
module dsau_checker (
	input wire        REF_CLK,
	input wire        RST,
	input wire        RD_REQ,
	input wire [1:0]  RD_AMODE,
	input wire [15:0] RD_POINTER,
	input wire [15:0] RD_FIELD,
	input wire        RD_IS_MOVE,
	input wire        RD_BYTE,
	input wire        RD_POST_INC,
	input wire        WR_REQ,
	input wire [1:0]  WR_AMODE,
	input wire [15:0] WR_POINTER,
	input wire        WR_BYTE,
	input wire        TRAP_ACK,
	input wire [14:0] MEM_WORD_ADDR,
	input wire        MEM_SEL,
	input wire        SREG_SEL,
	input wire        WIN_SEL,
	input wire [1:0]  MEM_WE,
	input wire [1:0]  SREG_WE,
	input wire [1:0]  WIN_WE,
	input wire        RD_VALID,
	input wire [15:0] RD_POINTER_NEXT,
	input wire        ADDR_ERR,
	input wire        MODE_ERR
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	wire rd_ind = RD_REQ && RD_AMODE == 2'h0;
	wire wr_ind = WR_REQ && WR_AMODE == 2'h0;
	wire rd_mis = rd_ind && !RD_BYTE && RD_POINTER[0];
	wire wr_mis = wr_ind && !WR_BYTE && WR_POINTER[0];
	wire rd_fault = RD_REQ && RD_AMODE == 2'h2 && !RD_IS_MOVE;
	wire no_sel = !MEM_SEL && !SREG_SEL && !WIN_SEL;
	sequence s_rd_ok; RD_REQ && !rd_fault; endsequence
	sequence s_rd_done; ##2 RD_VALID; endsequence
	property p_rd_lat; s_rd_ok |-> s_rd_done; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read not answered");
	property p_win; rd_ind && RD_POINTER[15] |-> WIN_SEL && !MEM_SEL && !SREG_SEL; endproperty
	a_win: assert property (p_win) else $error("upper half not windowed");
	property p_mem; rd_ind && !RD_POINTER[15] && RD_POINTER[14:11] != 4'h0 |-> MEM_SEL && !WIN_SEL; endproperty
	a_mem: assert property (p_mem) else $error("lower half not memory");
	property p_region; rd_ind && RD_POINTER[15:11] == 5'h00 |-> !MEM_SEL && !WIN_SEL; endproperty
	a_region: assert property (p_region) else $error("low 2 KB misrouted");
	property p_lane; wr_ind && WR_BYTE && !WR_POINTER[15] && WR_POINTER[14:11] != 4'h0
		|=> MEM_WE == ($past(WR_POINTER[0]) ? 2'b10 : 2'b01); endproperty
	a_lane: assert property (p_lane) else $error("wrong byte strobe");
	property p_wr_sup; wr_mis |=> MEM_WE == 2'b00 && SREG_WE == 2'b00 && WIN_WE == 2'b00; endproperty
	a_wr_sup: assert property (p_wr_sup) else $error("misaligned write stored");
	property p_err; (rd_mis || wr_mis) && !ADDR_ERR |=> ADDR_ERR; endproperty
	a_err: assert property (p_err) else $error("address error missing");
	property p_hold; ADDR_ERR && !TRAP_ACK |=> ADDR_ERR; endproperty
	a_hold: assert property (p_hold) else $error("address error dropped");
	property p_ptr; rd_ind && RD_POST_INC
		|=> RD_POINTER_NEXT == $past(RD_POINTER) + ($past(RD_BYTE) ? 16'h0001 : 16'h0002); endproperty
	a_ptr: assert property (p_ptr) else $error("pointer step wrong");
	property p_mode; rd_fault |-> no_sel ##1 MODE_ERR; endproperty
	a_mode: assert property (p_mode) else $error("full field without move");
	property p_near; RD_REQ && RD_AMODE == 2'h1 |-> MEM_WORD_ADDR == {3'h0, RD_FIELD[12:1]}; endproperty
	a_near: assert property (p_near) else $error("near field wrong");
endmodule
bind data_space_access_unit dsau_checker u_chk (.*);

// ===== tb/data_space_access_unit_test.sv
`timescale 1ns/1ps
`include "dspace_map.vh"
module data_space_access_unit_test;
	reg REF_CLK = 0, RST = 1, RD_REQ = 0, RD_IS_MOVE = 1, RD_BYTE = 0, RD_POST_INC = 1;
	reg WR_REQ = 0, WR_IS_MOVE = 0, WR_BYTE = 0, WR_POST_INC = 1, TRAP_ACK = 0;
	reg [1:0] RD_AMODE = 0, RD_XOP = 0, WR_AMODE = 0;
	reg [15:0] RD_POINTER = 0, RD_FIELD = 0, RD_REG_OLD = 0, WR_POINTER = 0, WR_FIELD = 0;
	reg [15:0] WR_DATA = 0;
	wire [15:0] MEM_RDATA, SREG_RDATA, WIN_RDATA, WR_LANE_DATA, RD_VALUE;
	wire [15:0] RD_POINTER_NEXT, WR_POINTER_NEXT;
	wire [14:0] MEM_WORD_ADDR, WR_WORD_ADDR;
	wire [1:0] MEM_WE, SREG_WE, WIN_WE;
	wire MEM_SEL, SREG_SEL, WIN_SEL, RD_VALID, ADDR_ERR, MODE_ERR;
	integer err_count = 0, checked = 0, i;
	reg [22:0] rows [0:9];
	data_space_access_unit dut (.*);
	dspace_far_model far (.clk(REF_CLK), .mem_sel(MEM_SEL), .sreg_sel(SREG_SEL),
		.win_sel(WIN_SEL), .word_addr(MEM_WORD_ADDR), .mem_rdata(MEM_RDATA),
		.sreg_rdata(SREG_RDATA), .win_rdata(WIN_RDATA));
	always #5 REF_CLK = ~REF_CLK;
	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	task tally_and_finish; begin
		if (err_count == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	end endtask
	task chk(input [15:0] got, input [15:0] exp); begin
		checked = checked + 1;
		if (got !== exp) begin
			err_count = err_count + 1;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	end endtask
	function [15:0] exp_rd(input [15:0] a, input byt, input [1:0] xop, input [1:0] src);
		reg [15:0] w;
		reg [7:0] b;
		begin
			w = {1'b0, a[15:1]} ^ (src == 2'd1 ? 16'h4321 : src == 2'd2 ? 16'h1234 : 16'h8765);
			if (src == 2'd0) w = 16'h0000;
			b = a[0] ? w[15:8] : w[7:0];
			if (!byt) exp_rd = w;
			else if (xop == `XOP_SIGN) exp_rd = {{8{b[7]}}, b};
			else if (xop == `XOP_ZERO) exp_rd = {8'h00, b};
			else exp_rd = {a[15:8] ^ 8'h5a, b};
		end
	endfunction
	// request for one cycle; returns while registered write results still stand
	task access(input rd, input [1:0] am, input [15:0] a, input byt, input [1:0] xop); begin
		@(negedge REF_CLK);
		{RD_REQ, WR_REQ} = {rd, !rd};
		{RD_AMODE, RD_POINTER, RD_FIELD, RD_BYTE, RD_XOP} = {am, a, a, byt, xop};
		{WR_POINTER, WR_BYTE, WR_DATA} = {a, byt, 16'h00ab};
		RD_REG_OLD = {a[15:8] ^ 8'h5a, 8'h00};
		@(negedge REF_CLK);
		{RD_REQ, WR_REQ} = 2'b00;
	end endtask
	// ---------------------------------------------
	// sequence
	// ---------------------------------------------
	initial begin
		// amode, address, byte, xop, answering side (0 none 1 reg 2 mem 3 window)
		rows[0] = {2'h0, 16'h0100, 1'b0, 2'h0, 2'd1};
		rows[1] = {2'h0, 16'h0101, 1'b1, 2'h0, 2'd1};
		rows[2] = {2'h0, 16'h0300, 1'b0, 2'h0, 2'd0};
		rows[3] = {2'h0, 16'h0200, 1'b0, 2'h0, 2'd0};
		rows[4] = {2'h0, 16'h01e0, 1'b0, 2'h0, 2'd1};
		rows[5] = {2'h0, 16'h0800, 1'b0, 2'h0, 2'd2};
		rows[6] = {2'h0, 16'h7ffe, 1'b1, 2'h1, 2'd2};
		rows[7] = {2'h1, 16'h1001, 1'b1, 2'h2, 2'd2};
		rows[8] = {2'h2, 16'h9000, 1'b0, 2'h0, 2'd3};
		rows[9] = {2'h0, 16'hfffe, 1'b1, 2'h1, 2'd3};
		repeat (16) @(negedge REF_CLK);
		RST = 0;
		chk({11'h0, RD_VALID, ADDR_ERR, MODE_ERR, MEM_WE}, 16'h0000);
		for (i = 0; i < 10; i = i + 1) begin
			access(1, rows[i][22:21], rows[i][20:5], rows[i][4], rows[i][3:2]);
			@(negedge REF_CLK);
			chk({15'h0, RD_VALID}, 16'h0001);
			chk(RD_VALUE, exp_rd(rows[i][20:5], rows[i][4], rows[i][3:2], rows[i][1:0]));
		end
		access(0, 2'h0, 16'h0901, 1, 0);
		chk({14'h0, MEM_WE}, 16'h0002);
		chk(WR_LANE_DATA, 16'habab);
		chk({1'b0, WR_WORD_ADDR}, 16'h0480);
		chk(WR_POINTER_NEXT, 16'h0902);
		access(0, 2'h0, 16'h0903, 0, 0);
		chk({13'h0, MEM_WE, ADDR_ERR}, 16'h0001);
		access(1, 2'h0, 16'h0903, 0, 0);
		@(negedge REF_CLK);
		chk({14'h0, RD_VALID, ADDR_ERR}, 16'h0003);
		TRAP_ACK = 1;
		@(negedge REF_CLK);
		TRAP_ACK = 0;
		@(negedge REF_CLK);
		chk({15'h0, ADDR_ERR}, 16'h0000);
		RD_IS_MOVE = 0;
		access(1, 2'h2, 16'h9000, 0, 0);
		chk({15'h0, MODE_ERR}, 16'h0001);
		RD_IS_MOVE = 1;
		@(negedge REF_CLK);
		chk({15'h0, RD_VALID}, 16'h0000);
		tally_and_finish;
	end
	initial begin
		#20000;
		err_count = err_count + 1;
		tally_and_finish;
	end
endmodule
